//--- design/ddsc_top.sv
// module: disk drive status and control pin logic
`timescale 1ns/100ps
module ddsc_top (
   // core clock and reset
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_n,
   // link clock
   input  wire logic                      i_read_reference_clock,
   // drive status inputs
   input  wire logic                      i_mark_found_in,
   input  wire logic                      i_seek_done_in,
   input  wire logic                      i_drive_failure_in,
   // sequencer control (core domain)
   input  wire logic                      i_seq_run,
   input  wire logic                      i_seq_aux_field,
   input  wire logic                      i_seek_irq_en,
   input  wire logic                      i_fail_branch_en,
   // general port eight
   input  wire logic [ddsc_pkg::GP8_W-1:0] i_general_port_eight,
   input  wire logic [ddsc_pkg::GP8_W-1:0] i_gp8_dout,
   input  wire logic [ddsc_pkg::GP8_W-1:0] i_gp8_dir,
   output logic      [ddsc_pkg::GP8_W-1:0] o_general_port_eight,
   output logic      [ddsc_pkg::GP8_W-1:0] o_general_port_eight_oe,
   output logic      [ddsc_pkg::GP8_W-1:0] o_gp8_din,
   // general port four
   input  wire logic [ddsc_pkg::GP4_W-1:0] i_general_port_four,
   input  wire logic [ddsc_pkg::GP4_W-1:0] i_gp4_dout,
   input  wire logic [ddsc_pkg::GP4_W-1:0] i_gp4_dir,
   output logic      [ddsc_pkg::GP4_W-1:0] o_general_port_four,
   output logic      [ddsc_pkg::GP4_W-1:0] o_general_port_four_oe,
   output logic      [ddsc_pkg::GP4_W-1:0] o_gp4_din,
   // link-domain outputs
   output logic                           o_sequencer_aux_out,
   // core-domain status
   output logic                           o_mark_found,
   output logic                           o_irq_seek,
   output logic                           o_irq_fail,
   output logic                           o_seq_error
);
   localparam int CW = ddsc_pkg::CFG_W;
   localparam int LW = ddsc_pkg::GP8_W + ddsc_pkg::GP4_W;
   localparam int SW = 4 + LW;

   // core to link configuration crossing
   logic [CW-1:0] cfg_core;
   logic [LW-1:0] gp_dout_core;
   logic [LW-1:0] gp_dir_core;
   always_comb begin
      cfg_core = ddsc_pkg::CFG_RST;
      cfg_core[ddsc_pkg::CFG_SEEK_IRQ_EN] = i_seek_irq_en;
      cfg_core[ddsc_pkg::CFG_FAIL_BRANCH] = i_fail_branch_en;
      cfg_core[ddsc_pkg::CFG_SEQ_RUN]     = i_seq_run;
      cfg_core[ddsc_pkg::CFG_AUX_OUT]     = i_seq_aux_field;
      gp_dout_core = {i_gp4_dout, i_gp8_dout};
      gp_dir_core  = {i_gp4_dir, i_gp8_dir};
   end

   // configuration levels are quasi-static; bitwise sync is accepted
   ddsc_sync_if #(.W(CW + 2 * LW)) c2l_if ();
   assign c2l_if.d = {gp_dir_core, gp_dout_core, cfg_core};
   ddsc_sync #(.W(CW + 2 * LW)) u_c2l (
      .i_clk   (i_read_reference_clock),
      .i_rst_n (i_rst_n),
      .s       (c2l_if)
   );
   logic [CW-1:0] cfg_l;
   logic [LW-1:0] dout_l;
   logic [LW-1:0] dir_l;
   assign cfg_l  = c2l_if.q[CW-1:0];
   assign dout_l = c2l_if.q[CW+LW-1:CW];
   assign dir_l  = c2l_if.q[CW+2*LW-1:CW+LW];

   // pin inputs into the link domain
   ddsc_sync_if #(.W(3 + LW)) pin_if ();
   assign pin_if.d = {i_general_port_four, i_general_port_eight,
                      i_drive_failure_in, i_seek_done_in,
                      i_mark_found_in};
   ddsc_sync #(.W(3 + LW)) u_pin (
      .i_clk   (i_read_reference_clock),
      .i_rst_n (i_rst_n),
      .s       (pin_if)
   );

   // link-domain state
   logic [LW-1:0] pin_out_ff;
   logic [LW-1:0] pin_oe_ff;
   logic [LW-1:0] pin_in_ff;
   logic          aux_ff;
   logic          mark_l_ff;
   logic          seek_l_ff;
   logic          fail_l_ff;
   logic          branch_l_ff;
   logic [LW-1:0] nxt_pin_out;
   logic [LW-1:0] nxt_pin_oe;
   logic [LW-1:0] nxt_pin_in;
   logic          nxt_aux;
   logic          nxt_mark_l;
   logic          nxt_seek_l;
   logic          nxt_fail_l;
   logic          nxt_branch_l;
   logic          run_l;

   assign run_l = cfg_l[ddsc_pkg::CFG_SEQ_RUN];

   always_comb begin
      nxt_aux    = cfg_l[ddsc_pkg::CFG_AUX_OUT];
      nxt_mark_l = pin_if.q[0];
      // ignored while the sequencer is idle
      nxt_seek_l = pin_if.q[1] & run_l &
                   cfg_l[ddsc_pkg::CFG_SEEK_IRQ_EN];
      nxt_fail_l = pin_if.q[2];
      nxt_branch_l = pin_if.q[2] & run_l &
                     cfg_l[ddsc_pkg::CFG_FAIL_BRANCH];
   end

   // per-pin direction: dir bit high makes the pin an output
   genvar g;
   generate
      for (g = 0; g < LW; g++) begin : g_pin
         always_comb begin
            nxt_pin_out[g] = dout_l[g] & dir_l[g];
            nxt_pin_oe[g]  = dir_l[g];
            nxt_pin_in[g]  = pin_if.q[3 + g];
         end
      end
   endgenerate

   // pin group
   always_ff @(posedge i_read_reference_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_out_ff  <= {ddsc_pkg::GP4_RST, ddsc_pkg::GP8_RST};
         pin_oe_ff   <= '0;
         pin_in_ff   <= '0;
      end else begin
         pin_out_ff  <= nxt_pin_out;
         pin_oe_ff   <= nxt_pin_oe;
         pin_in_ff   <= nxt_pin_in;
      end
   end

   // flag group
   always_ff @(posedge i_read_reference_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aux_ff      <= 1'b0;
         mark_l_ff   <= 1'b0;
         seek_l_ff   <= 1'b0;
         fail_l_ff   <= 1'b0;
         branch_l_ff <= 1'b0;
      end else begin
         aux_ff      <= nxt_aux;
         mark_l_ff   <= nxt_mark_l;
         seek_l_ff   <= nxt_seek_l;
         fail_l_ff   <= nxt_fail_l;
         branch_l_ff <= nxt_branch_l;
      end
   end

   assign o_general_port_eight    = pin_out_ff[ddsc_pkg::GP8_W-1:0];
   assign o_general_port_eight_oe = pin_oe_ff[ddsc_pkg::GP8_W-1:0];
   assign o_general_port_four     = pin_out_ff[LW-1:ddsc_pkg::GP8_W];
   assign o_general_port_four_oe  = pin_oe_ff[LW-1:ddsc_pkg::GP8_W];
   assign o_sequencer_aux_out     = aux_ff;

   // link to core status crossing
   // read clock may stop; core sees the last sampled level
   ddsc_sync_if #(.W(SW)) l2c_if ();
   assign l2c_if.d = {pin_in_ff, branch_l_ff, fail_l_ff, seek_l_ff,
                      mark_l_ff};
   ddsc_sync #(.W(SW)) u_l2c (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .s       (l2c_if)
   );

   // core-domain state
   ddsc_pkg::ddsc_seq_e seq_ff;
   ddsc_pkg::ddsc_seq_e nxt_seq;
   logic          seq_err_ff;
   logic          nxt_seq_err;
   logic          mark_ff;
   logic          irq_seek_ff;
   logic          irq_fail_ff;
   logic [LW-1:0] gp_in_ff;
   logic          nxt_mark;
   logic          nxt_irq_seek;
   logic          nxt_irq_fail;
   logic [LW-1:0] nxt_gp_in;

   // status group: levels, not sticky, so they drop with their inputs
   always_comb begin
      nxt_mark     = l2c_if.q[0];
      // gated here too, so a dropped enable acts without crossing delay
      nxt_irq_seek = l2c_if.q[1] & i_seq_run &
                     i_seek_irq_en;
      nxt_irq_fail = l2c_if.q[2];
      nxt_gp_in    = l2c_if.q[4 +: LW];
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mark_ff     <= 1'b0;
         irq_seek_ff <= 1'b0;
         irq_fail_ff <= 1'b0;
         gp_in_ff    <= '0;
      end else begin
         mark_ff     <= nxt_mark;
         irq_seek_ff <= nxt_irq_seek;
         irq_fail_ff <= nxt_irq_fail;
         gp_in_ff    <= nxt_gp_in;
      end
   end

   // sequencer group
   always_comb begin
      nxt_seq = seq_ff;
      case (seq_ff)
         ddsc_pkg::DDSC_SEQ_IDLE: begin
            if (i_seq_run) begin
               nxt_seq = ddsc_pkg::DDSC_SEQ_RUN;
            end
         end
         ddsc_pkg::DDSC_SEQ_RUN: begin
            if (!i_seq_run) begin
               nxt_seq = ddsc_pkg::DDSC_SEQ_IDLE;
            end else if (l2c_if.q[3] & i_fail_branch_en) begin
               nxt_seq = ddsc_pkg::DDSC_SEQ_ERR;
            end
         end
         default: begin
            // error routine runs until the sequencer is stopped
            if (!i_seq_run) begin
               nxt_seq = ddsc_pkg::DDSC_SEQ_IDLE;
            end
         end
      endcase
      // registered copy keeps the error output straight from a flop
      nxt_seq_err = (nxt_seq == ddsc_pkg::DDSC_SEQ_ERR);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         seq_ff     <= ddsc_pkg::DDSC_SEQ_IDLE;
         seq_err_ff <= 1'b0;
      end else begin
         seq_ff     <= nxt_seq;
         seq_err_ff <= nxt_seq_err;
      end
   end

   assign o_mark_found = mark_ff;
   assign o_irq_seek   = irq_seek_ff;
   assign o_irq_fail   = irq_fail_ff;
   assign o_seq_error  = seq_err_ff;
   assign o_gp8_din    = gp_in_ff[ddsc_pkg::GP8_W-1:0];
   assign o_gp4_din    = gp_in_ff[LW-1:ddsc_pkg::GP8_W];
endmodule // ddsc_top

//--- design/ddsc_pkg.sv
// package: constants and types shared by the disk status/control pin block
package ddsc_pkg;
   localparam int GP8_W      = 8;
   localparam int GP4_W      = 4;
   localparam int SYNC_STAGES = 2;
   localparam logic [GP8_W-1:0] GP8_RST = 8'h00;
   localparam logic [GP4_W-1:0] GP4_RST = 4'h0;
   // number of core-domain flags carried to the link domain
   localparam int CFG_W = 4;
   localparam int CFG_SEEK_IRQ_EN  = 0;
   localparam int CFG_FAIL_BRANCH  = 1;
   localparam int CFG_SEQ_RUN      = 2;
   localparam int CFG_AUX_OUT      = 3;
   localparam logic [CFG_W-1:0] CFG_RST = 4'h0;
   typedef enum logic [1:0] {
      DDSC_SEQ_IDLE,
      DDSC_SEQ_RUN,
      DDSC_SEQ_ERR
   } ddsc_seq_e;
endpackage

//--- design/ddsc_sync_if.sv
// interface: bundle of synchroniser input and output
`timescale 1ns/100ps
interface ddsc_sync_if #(parameter int W = 1);
   logic [W-1:0] d;
   logic [W-1:0] q;
   modport src (output d, input q);
   modport snk (input d, output q);
endinterface

//--- design/ddsc_sync.sv
// module: two-flop level synchroniser, one per bit
`timescale 1ns/100ps
module ddsc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // levels
   ddsc_sync_if.snk  s
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_sync;

   // first stage is read only by the second stage
   always_comb begin
      nxt_meta = s.d;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign s.q = sync_ff;
endmodule // ddsc_sync

//--- verif/ddsc_top_monitor.sv
// checker: port assertions of the disk status and control pin block
`timescale 1ns/100ps
module ddsc_top_monitor (
   // clock and reset
   input wire logic       i_clk,
   input wire logic       i_rst_n,
   // watched inputs
   input wire logic       i_drive_failure_in,
   input wire logic       i_seek_done_in,
   input wire logic       i_seq_run,
   input wire logic       i_seq_aux_field,
   input wire logic       i_seek_irq_en,
   input wire logic       i_fail_branch_en,
   input wire logic [7:0] i_gp8_dir,
   // watched outputs
   input wire logic [7:0] o_general_port_eight,
   input wire logic [7:0] o_general_port_eight_oe,
   input wire logic       o_sequencer_aux_out,
   input wire logic       o_irq_seek,
   input wire logic       o_irq_fail,
   input wire logic       o_seq_error
);
   // cycles with seek interrupts not allowed; saturates
   logic [5:0] quiet_ff;
   logic [5:0] nxt_quiet;
   always_comb begin
      nxt_quiet = (quiet_ff == 6'h3f) ? quiet_ff : quiet_ff + 6'h01;
      if (i_seq_run && i_seek_irq_en) nxt_quiet = 6'h00;
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) quiet_ff <= 6'h00;
      else quiet_ff <= nxt_quiet;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   AST_FAIL_RAISE:
      assert property ($rose(i_drive_failure_in) |-> ##[1:40] o_irq_fail)
         else $error("fail irq late");
   AST_FAIL_SYNC:
      assert property ($rose(i_drive_failure_in) |-> !o_irq_fail[*4])
         else $error("fail irq not synchronised");
   AST_FAIL_DROP:
      assert property ($fell(i_drive_failure_in) |-> ##[1:40] !o_irq_fail)
         else $error("fail irq stuck");
   AST_SEEK_RAISE:
      assert property ($rose(i_seek_done_in) && i_seq_run && i_seek_irq_en
         |-> ##[1:40] o_irq_seek) else $error("seek irq late");
   AST_SEEK_IDLE:
      assert property (quiet_ff == 6'h3f |-> !o_irq_seek)
         else $error("seek irq while idle");
   AST_BRANCH:
      assert property ($rose(o_seq_error) |-> o_irq_fail && i_seq_run
         && i_fail_branch_en) else $error("bad error branch");
   AST_ERR_EXIT:
      assert property ($fell(i_seq_run) |-> ##[1:40] !o_seq_error)
         else $error("error state stuck");
   AST_AUX:
      assert property ($changed(i_seq_aux_field)
         |-> ##[1:40] o_sequencer_aux_out == i_seq_aux_field)
         else $error("aux out wrong");
   AST_GP_DIR:
      assert property ($changed(i_gp8_dir)
         |-> ##[1:40] o_general_port_eight_oe == i_gp8_dir)
         else $error("port enable wrong");
   AST_GP_IDLE:
      assert property ((o_general_port_eight & ~o_general_port_eight_oe)
         == 8'h00) else $error("input pin driven");
   cover property (o_seq_error);
   cover property (o_irq_seek);
   cover property (o_general_port_eight_oe == 8'hff);
endmodule // ddsc_top_monitor
bind ddsc_top ddsc_top_monitor i_mon (.i_clk, .i_rst_n, .i_drive_failure_in,
   .i_seek_done_in, .i_seq_run, .i_seq_aux_field, .i_seek_irq_en,
   .i_fail_branch_en, .i_gp8_dir, .o_general_port_eight,
   .o_general_port_eight_oe, .o_sequencer_aux_out, .o_irq_seek, .o_irq_fail,
   .o_seq_error);

//--- verif/ddsc_drive_model.sv
// model: read channel and drive electronics facing the pin block
`timescale 1ns/100ps
module ddsc_drive_model (
   // commands from the bench
   input  wire logic [2:0] i_flags,
   input  wire logic [7:0] i_pin8,
   input  wire logic [3:0] i_pin4,
   // device pin drive
   input  wire logic [7:0] i_out8,
   input  wire logic [7:0] i_oe8,
   input  wire logic [3:0] i_out4,
   input  wire logic [3:0] i_oe4,
   // lines toward the device
   output logic            o_read_reference_clock,
   output logic [2:0]      o_flags,
   output logic [7:0]      o_pin8,
   output logic [3:0]      o_pin4
);
   // reference clock runs free, phase unrelated to the core clock
   initial o_read_reference_clock = 1'b0;
   always #7.5 o_read_reference_clock = ~o_read_reference_clock;
   // flags only change on the reference clock, as a real channel does
   initial o_flags = 3'h0;
   always @(posedge o_read_reference_clock) o_flags <= i_flags;
   // each pin shows the device level where it drives, else ours
   assign o_pin8 = (i_oe8 & i_out8) | (~i_oe8 & i_pin8);
   assign o_pin4 = (i_oe4 & i_out4) | (~i_oe4 & i_pin4);
endmodule // ddsc_drive_model

//--- verif/test_ddsc_top.sv
// testbench: drives flags, sequencer levels and general ports
`timescale 1ns/100ps
module test_ddsc_top;
   logic       i_clk, i_rst_n, i_seq_run, i_seq_aux_field, i_seek_irq_en;
   logic       i_fail_branch_en, i_read_reference_clock, o_mark_found;
   logic       i_mark_found_in, i_seek_done_in, i_drive_failure_in;
   logic       o_sequencer_aux_out, o_irq_seek, o_irq_fail, o_seq_error;
   logic [2:0] flags, drv_flags;
   logic [7:0] i_general_port_eight, i_gp8_dout, i_gp8_dir, o_gp8_din;
   logic [7:0] o_general_port_eight, o_general_port_eight_oe, pin8;
   logic [3:0] i_general_port_four, i_gp4_dout, i_gp4_dir, o_gp4_din;
   logic [3:0] o_general_port_four, o_general_port_four_oe, pin4;
   logic [7:0] exp8;
   logic [3:0] exp4;
   int         bad_count, n_compared, cyc;
   ddsc_top i_dut (.i_clk, .i_rst_n, .i_read_reference_clock,
      .i_mark_found_in, .i_seek_done_in, .i_drive_failure_in, .i_seq_run,
      .i_seq_aux_field, .i_seek_irq_en, .i_fail_branch_en,
      .i_general_port_eight, .i_gp8_dout, .i_gp8_dir, .o_general_port_eight,
      .o_general_port_eight_oe, .o_gp8_din, .i_general_port_four,
      .i_gp4_dout, .i_gp4_dir, .o_general_port_four, .o_general_port_four_oe,
      .o_gp4_din, .o_sequencer_aux_out, .o_mark_found, .o_irq_seek,
      .o_irq_fail, .o_seq_error);
   ddsc_drive_model i_drv (.i_flags(flags), .i_pin8(pin8), .i_pin4(pin4),
      .i_out8(o_general_port_eight), .i_oe8(o_general_port_eight_oe),
      .i_out4(o_general_port_four), .i_oe4(o_general_port_four_oe),
      .o_read_reference_clock(i_read_reference_clock), .o_pin8(i_general_port_eight),
      .o_flags(drv_flags), .o_pin4(i_general_port_four));
   assign {i_mark_found_in, i_seek_done_in, i_drive_failure_in} = drv_flags;
   initial i_clk = 1'b0;
   always #2 i_clk = ~i_clk;
   task check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task results;
      $display("mismatches %0d of %0d compares", bad_count, n_compared);
      if (bad_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // c = run, aux, seek enable, branch enable; f = mark, seek, fail
   task put(input logic [3:0] c, input logic [2:0] f);
      @(posedge i_clk);
      {i_seq_run, i_seq_aux_field, i_seek_irq_en, i_fail_branch_en} <= c;
      flags <= f;
      repeat (40) @(posedge i_clk);
      #1;
   endtask
   // a hang costs a mismatch and still reaches the report
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         results();
      end
   end
   initial begin
      {i_rst_n, i_seq_run, i_seq_aux_field, i_seek_irq_en} = 4'h0;
      {i_fail_branch_en, flags, pin8, pin4} = 16'h0000;
      {i_gp8_dout, i_gp8_dir, i_gp4_dout, i_gp4_dir} = 24'h000000;
      {bad_count, n_compared, cyc} = '0;
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      put(4'h0, 3'h2);
      check(o_irq_seek, 8'h00);
      put(4'h8, 3'h2);
      check(o_irq_seek, 8'h00);
      put(4'ha, 3'h0);
      check(o_irq_seek, 8'h00);
      put(4'ha, 3'h2);
      check(o_irq_seek, 8'h01);
      put(4'ha, 3'h4);
      check({o_irq_seek, o_mark_found}, 8'h01);
      put(4'h4, 3'h0);
      check(o_sequencer_aux_out, 8'h01);
      put(4'h0, 3'h0);
      check(o_sequencer_aux_out, 8'h00);
      put(4'h9, 3'h1);
      check({o_irq_fail, o_seq_error}, 8'h03);
      put(4'h8, 3'h1);
      check({o_irq_fail, o_seq_error}, 8'h03);
      put(4'h1, 3'h1);
      check({o_irq_fail, o_seq_error}, 8'h02);
      put(4'h8, 3'h1);
      check({o_irq_fail, o_seq_error}, 8'h02);
      put(4'h0, 3'h0);
      check({o_irq_fail, o_seq_error}, 8'h00);
      for (int k = 0; k < 3; k++) begin
         @(posedge i_clk);
         i_gp8_dir  <= 8'hff >> (4 * k);
         i_gp4_dir  <= 4'hf >> (2 * k);
         i_gp8_dout <= 8'ha5 ^ {8{k[0]}};
         i_gp4_dout <= 4'h9 ^ {4{k[0]}};
         pin8       <= 8'h3c ^ {8{k[0]}};
         pin4       <= 4'h6 ^ {4{k[0]}};
         put(4'h0, 3'h0);
         exp8 = (i_gp8_dout & i_gp8_dir) | (pin8 & ~i_gp8_dir);
         exp4 = (i_gp4_dout & i_gp4_dir) | (pin4 & ~i_gp4_dir);
         check(o_general_port_eight_oe, i_gp8_dir);
         check(o_general_port_eight, i_gp8_dout & i_gp8_dir);
         check(o_gp8_din, exp8);
         check(o_general_port_four_oe, i_gp4_dir);
         check(o_general_port_four, i_gp4_dout & i_gp4_dir);
         check(o_gp4_din, exp4);
      end
      results();
   end
endmodule // test_ddsc_top
